// ---- rtl/adcmp_map.svh ----
`ifndef ADCMP_MAP_SVH
`define ADCMP_MAP_SVH
// configuration word reset value and field positions
`define ADCMP_CFG_RESET 32'h000003FF
`define ADCMP_BIT_PAIR_EN_HI 31
`define ADCMP_BIT_PAIR_EN_LO 29
`define ADCMP_BIT_INTERLEAVE 23
`define ADCMP_BIT_AUTO_DOZE 22
`define ADCMP_BIT_BUSY_INT 21
`define ADCMP_BIT_BUSY_POL 20
`define ADCMP_BIT_READ_CFG 17
`define ADCMP_BIT_FULL_UPD 16
`define ADCMP_BIT_PD_HI 15
`define ADCMP_BIT_PD_LO 13
`define ADCMP_BIT_EXT_CCLK 11
// hardware-mode mask: C[22:18], C[15:13], C[9:0]
`define ADCMP_HW_MASK 32'h007CE3FF
// reserved bits C19 and C12
`define ADCMP_RSVD_MASK 32'h00081000
// pins whose idle level is high: sleep request, chip select, strobe, frame sync, sclk
`define ADCMP_SYNC_IDLE 37'h008C000300
`define ADCMP_TOP_MASK 32'hFF000000
// serial frame and timing
`define ADCMP_FRAME_BITS 6'h20
`define ADCMP_RESULT_BITS 6'h20
`define ADCMP_WAKE_CCLKS 5'h06
`define ADCMP_CONV_CCLKS 5'h12
`define ADCMP_SETTLE_MS 10
`define ADCMP_CLK_HZ 40000000
`endif

// ---- rtl/adcmp_pkg.sv ----
package adcmp_pkg;
  // pin-level controls grouped together
  typedef struct packed {
    logic control_source_select;
    logic sleep_request_n;
    logic chain_enable;
    logic serial_mode;
    logic byte_mode;
  } adcmp_pins_t;
  // power state: per-pair down bits, shared doze, standby and ready
  typedef struct packed {
    logic [2:0] powerdown;
    logic [2:0] partial_down;
    logic dozing;
    logic standby;
    logic ready;
  } adcmp_power_t;
  typedef enum logic [1:0] {
    ADCMP_IDLE = 2'b00,
    ADCMP_WAKE = 2'b01,
    ADCMP_CONV = 2'b10
  } adcmp_conv_state_t;
endpackage

// ---- rtl/adcmp_sync.sv ----
`timescale 1ns/1ps
`default_nettype none
// two-flop synchroniser for a bundle of pin levels
module adcmp_sync #(
  parameter int WIDTH = 1
) (
  input wire logic mclk,
  input wire logic srst,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta;
  // first stage feeds only the second
  always_ff @(posedge mclk) begin
    if (srst) begin
      meta <= '0;
      sync_out <= '0;
    end else begin
      meta <= async_in;
      sync_out <= meta;
    end
  end
endmodule
`default_nettype wire

// ---- rtl/adcmp_serial.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "adcmp_map.svh"
// serial frame engine: samples input on falling sclk, shifts out on rising sclk
module adcmp_serial
  import adcmp_pkg::*;
(
  input wire logic mclk,
  input wire logic srst,
  input wire logic frame_active,
  input wire logic sclk_rise,
  input wire logic sclk_fall,
  input wire logic frame_start,
  input wire logic serial_in,
  input wire logic [2:0] chain_in,
  input wire logic chain_enable,
  input wire logic [95:0] load_data,
  output logic [2:0] serial_result_out,
  output logic [31:0] rx_word,
  output logic rx_done
);
  logic [31:0] rx_shift;
  logic [5:0] rx_count;
  logic [95:0] tx_shift;
  wire [31:0] next_rx_shift = {rx_shift[30:0], serial_in};
  wire rx_last = (rx_count == `ADCMP_FRAME_BITS - 6'h01);
  // capture on falling edge; word complete on the 32nd falling edge
  always_ff @(posedge mclk) begin
    if (srst || frame_start) begin
      rx_shift <= '0;
      rx_count <= '0;
      rx_done <= 1'b0;
      rx_word <= '0;
    end else begin
      rx_done <= 1'b0;
      if (frame_active && sclk_fall && rx_count != `ADCMP_FRAME_BITS) begin
        rx_shift <= next_rx_shift;
        rx_count <= rx_count + 6'h01;
        if (rx_last) begin
          rx_word <= next_rx_shift;
          rx_done <= 1'b1;
        end
      end
    end
  end
  // msb first; in chain mode upstream data fills behind own result
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_lane
      wire fill = chain_enable ? chain_in[g] : 1'b0;
      always_ff @(posedge mclk) begin
        if (srst) begin
          tx_shift[g*32 +: 32] <= '0;
        end else if (frame_start) begin
          tx_shift[g*32 +: 32] <= load_data[g*32 +: 32];
        end else if (frame_active && sclk_rise) begin
          tx_shift[g*32 +: 32] <= {tx_shift[g*32 +: 31], fill};
        end
      end
      assign serial_result_out[g] = tx_shift[g*32 + 31];
    end
  endgenerate
endmodule
`default_nettype wire

// ---- rtl/adcmp_ctrl.sv ----
// Operation
// - hardware mode: pins rule, plus C[22:18], C[15:13], C[9:0] from register
// - software mode: whole configuration word applies; standby, serial, byte and chain selects stay on pins
// - parallel update: two word writes or four byte writes, chip select low
// - single upper-lane write changes only C[31:24]
// - word mode: first write sets C[31:24], holds C[23:16] for second
// - chain mode uses three data pins as chain inputs for pairs A-C
// - sequential mode only with software mode, external clock, interleave bit
// - sequential mode: one conversion-clock busy pulse, polarity from C20
// - reset aborts conversion, restores word to 0x000003FF, sample mode
// - standby keeps word and interface; host waits 10 ms after wake
// - pair power-down bit switches pair off; 10 ms settle after clear
// - pair power-down only in software mode, released back in hardware mode
// - trigger low while busy puts pair in partial power-down until reset
// - auto-doze: sleep after conversion, wake on trigger, convert six later
// - word writable only in software mode, kept in hardware mode
// - new word takes effect at write strobe rise or 32nd falling sclk
// - serial input sampled on falling edge, output changes on rising edge
// - serial full update bit low limits update to C[31:24]
`timescale 1ns/1ps
`default_nettype none
`include "adcmp_map.svh"
module adcmp_ctrl
  import adcmp_pkg::*;
#(
  parameter int SETTLE_CYCLES = `ADCMP_SETTLE_MS * (`ADCMP_CLK_HZ / 1000)
) (
  input wire logic mclk,
  input wire logic srst,
  input wire logic reset_pin,
  input wire adcmp_pins_t pins,
  input wire logic chip_select_n,
  input wire logic write_strobe_n,
  input wire logic [15:0] parallel_data_bus,
  input wire logic frame_sync_n,
  input wire logic sclk,
  input wire logic serial_in,
  input wire logic [2:0] chain_in,
  input wire logic conv_clock,
  input wire logic [2:0] pair_convert_trigger,
  input wire logic [95:0] result_data,
  input wire logic [2:0] hw_pin_pd,
  output logic [31:0] configuration_word,
  output logic [31:0] effective_config,
  output adcmp_power_t power,
  output logic [2:0] pair_sampling,
  output logic busy,
  output logic [2:0] serial_result_out
);
  // ****************************************************************
  // pin synchronisation
  // ****************************************************************
  localparam int NSYNC = 37;
  logic [NSYNC-1:0] sync_q;
  // idle-high pins pass inverted, so a freshly reset sync reads idle and no false edge follows
  wire [NSYNC-1:0] sync_in = {hw_pin_pd, reset_pin, pins, chip_select_n, write_strobe_n,
    parallel_data_bus, frame_sync_n, sclk, serial_in, chain_in, conv_clock,
    pair_convert_trigger} ^ `ADCMP_SYNC_IDLE;
  adcmp_sync #(.WIDTH(NSYNC)) u_sync (
    .mclk(mclk),
    .srst(srst),
    .async_in(sync_in),
    .sync_out(sync_q)
  );
  wire [NSYNC-1:0] s_all = sync_q ^ `ADCMP_SYNC_IDLE;
  wire [2:0] s_pd = s_all[36:34];
  wire s_reset = s_all[33];
  adcmp_pins_t s_pins;
  assign s_pins = s_all[32:28];
  wire s_cs_n = s_all[27];
  wire s_wr_n = s_all[26];
  wire [15:0] s_db = s_all[25:10];
  wire s_fs_n = s_all[9];
  wire s_sclk = s_all[8];
  wire s_sdi = s_all[7];
  wire [2:0] s_chain = s_all[6:4];
  wire s_cclk = s_all[3];
  wire [2:0] s_trig = s_all[2:0];
  // ****************************************************************
  // edge detection
  // ****************************************************************
  logic wr_n_d, sclk_d, fs_n_d, cclk_d;
  logic [2:0] trig_d;
  always_ff @(posedge mclk) begin
    if (srst) begin
      wr_n_d <= 1'b1;
      sclk_d <= 1'b1; // sclk parks high between frames
      fs_n_d <= 1'b1;
      cclk_d <= 1'b0;
      trig_d <= '0;
    end else begin
      wr_n_d <= s_wr_n;
      sclk_d <= s_sclk;
      fs_n_d <= s_fs_n;
      cclk_d <= s_cclk;
      trig_d <= s_trig;
    end
  end
  wire wr_rise = s_wr_n && !wr_n_d;
  wire sclk_rise = s_sclk && !sclk_d;
  wire sclk_fall = !s_sclk && sclk_d;
  wire frame_start = !s_fs_n && fs_n_d;
  wire cclk_rise = s_cclk && !cclk_d;
  wire [2:0] trig_rise = s_trig & ~trig_d;
  wire master_reset = srst || s_reset;
  wire sw_mode = s_pins.control_source_select;
  // ****************************************************************
  // parallel configuration writes
  // ****************************************************************
  logic [1:0] wr_index;
  logic [7:0] held_mid;
  logic [15:0] byte_hold;
  wire par_write = sw_mode && !s_pins.serial_mode && !s_cs_n && wr_rise;
  wire [1:0] next_wr_index = wr_index + 2'h1;
  // word mode: write 0 top byte + hold mid; write 1 mid + low half
  always_ff @(posedge mclk) begin
    if (master_reset || s_cs_n) begin
      wr_index <= '0;
      held_mid <= '0;
      byte_hold <= '0;
    end else if (par_write) begin
      wr_index <= s_pins.byte_mode ? next_wr_index : {1'b0, ~wr_index[0]};
      if (!s_pins.byte_mode && wr_index == 2'h0) begin
        held_mid <= s_db[7:0];
      end
      if (s_pins.byte_mode && wr_index == 2'h1) begin
        held_mid <= s_db[15:8];
      end
      if (s_pins.byte_mode && wr_index == 2'h2) begin
        byte_hold[15:8] <= s_db[15:8];
      end
    end
  end
  // ****************************************************************
  // serial engine
  // ****************************************************************
  logic [31:0] rx_word;
  logic rx_done;
  logic frame_active;
  always_ff @(posedge mclk) begin
    if (srst) begin
      frame_active <= 1'b0;
    end else begin
      frame_active <= s_pins.serial_mode && !s_fs_n;
    end
  end
  wire [95:0] tx_load = configuration_word[`ADCMP_BIT_READ_CFG] ?
    {3{configuration_word}} : result_data;
  adcmp_serial u_serial (
    .mclk(mclk),
    .srst(master_reset),
    .frame_active(frame_active),
    .sclk_rise(sclk_rise),
    .sclk_fall(sclk_fall),
    .frame_start(frame_start),
    .serial_in(s_sdi),
    .chain_in(s_chain),
    .chain_enable(s_pins.chain_enable),
    .load_data(tx_load),
    .serial_result_out(serial_result_out),
    .rx_word(rx_word),
    .rx_done(rx_done)
  );
  // ****************************************************************
  // configuration word
  // ****************************************************************
  wire ser_full = rx_word[`ADCMP_BIT_FULL_UPD];
  wire [31:0] ser_word = ser_full ? rx_word :
    ((rx_word & `ADCMP_TOP_MASK) | (configuration_word & ~`ADCMP_TOP_MASK));
  wire ser_write = sw_mode && s_pins.serial_mode && rx_done;
  wire word_second = !s_pins.byte_mode && wr_index == 2'h1;
  wire byte_last = s_pins.byte_mode && wr_index == 2'h3;
  logic [31:0] next_config;
  always_comb begin
    next_config = configuration_word;
    if (ser_write) begin
      next_config = ser_word;
    end else if (par_write) begin
      if (word_second) begin
        next_config = {configuration_word[31:24], held_mid, s_db};
      end else if (byte_last) begin
        next_config = {configuration_word[31:24], held_mid, byte_hold[15:8], s_db[15:8]};
      end else if (wr_index == 2'h0) begin
        next_config[31:24] = s_db[15:8];
      end
    end
  end
  // reserved bits C19 and C12 forced low
  always_ff @(posedge mclk) begin
    if (master_reset) begin
      configuration_word <= `ADCMP_CFG_RESET;
    end else begin
      configuration_word <= next_config & ~`ADCMP_RSVD_MASK;
    end
  end
  // hardware mode: pins rule except the masked fields
  assign effective_config = sw_mode ? configuration_word :
    (configuration_word & `ADCMP_HW_MASK);
  // ****************************************************************
  // power control
  // ****************************************************************
  wire seq_mode = sw_mode && configuration_word[`ADCMP_BIT_EXT_CCLK] &&
    configuration_word[`ADCMP_BIT_INTERLEAVE];
  wire [2:0] pd_bits = sw_mode ?
    configuration_word[`ADCMP_BIT_PD_HI:`ADCMP_BIT_PD_LO] : 3'h0;
  assign power.powerdown = pd_bits | (sw_mode ? 3'h0 : s_pd);
  assign power.standby = !s_pins.sleep_request_n;
  logic [31:0] settle_cnt;
  logic [2:0] pd_prev;
  wire wake_event = (pd_prev & ~pd_bits) != 3'h0;
  // settle timer after standby release or pair power-up
  always_ff @(posedge mclk) begin
    if (master_reset) begin
      settle_cnt <= '0;
      pd_prev <= '0;
    end else begin
      pd_prev <= pd_bits;
      if (power.standby || wake_event) begin
        settle_cnt <= 32'(SETTLE_CYCLES);
      end else if (settle_cnt != 32'h0) begin
        settle_cnt <= settle_cnt - 32'h1;
      end
    end
  end
  assign power.ready = (settle_cnt == 32'h0) && !power.standby;
  // ****************************************************************
  // conversion sequencing on conversion clock edges
  // ****************************************************************
  adcmp_conv_state_t state [3];
  logic [4:0] cnt [3];
  logic [2:0] eoc;
  logic [2:0] partial;
  logic dozing;
  wire busy_pol = effective_config[`ADCMP_BIT_BUSY_POL];
  genvar p;
  generate
    for (p = 0; p < 3; p++) begin : g_pair
      wire start = trig_rise[p] && !power.powerdown[p] && !partial[p] && !power.standby;
      always_ff @(posedge mclk) begin
        if (master_reset) begin
          state[p] <= ADCMP_IDLE;
          cnt[p] <= '0;
          eoc[p] <= 1'b0;
          partial[p] <= 1'b0;
        end else begin
          eoc[p] <= 1'b0;
          unique case (state[p])
            ADCMP_IDLE: begin
              if (start) begin
                state[p] <= ADCMP_WAKE;
                cnt[p] <= `ADCMP_WAKE_CCLKS;
              end
            end
            ADCMP_WAKE: begin
              if (cclk_rise) begin
                cnt[p] <= cnt[p] - 5'h01;
                if (cnt[p] == 5'h01) begin
                  state[p] <= ADCMP_CONV;
                  cnt[p] <= `ADCMP_CONV_CCLKS;
                end
              end
            end
            ADCMP_CONV: begin
              // busy is up for this state except during the sequential-mode end pulse; the pin level may be inverted by C20
              if (!s_trig[p]) begin
                partial[p] <= 1'b1;
              end
              if (cclk_rise) begin
                cnt[p] <= cnt[p] - 5'h01;
                if (cnt[p] == 5'h01) begin
                  state[p] <= ADCMP_IDLE;
                  eoc[p] <= 1'b1;
                end
              end
            end
            default: state[p] <= ADCMP_IDLE;
          endcase
        end
      end
      assign pair_sampling[p] = (state[p] != ADCMP_CONV);
    end
  endgenerate
  wire [2:0] converting = {state[2] == ADCMP_CONV, state[1] == ADCMP_CONV,
                           state[0] == ADCMP_CONV};
  // sequential mode pulse: one conversion clock wide when others still run
  logic seq_pulse;
  always_ff @(posedge mclk) begin
    if (master_reset) begin
      seq_pulse <= 1'b0;
      dozing <= 1'b0;
    end else begin
      if (seq_mode && eoc != 3'h0 && (converting & ~eoc) != 3'h0) begin
        seq_pulse <= 1'b1;
      end else if (cclk_rise) begin
        seq_pulse <= 1'b0;
      end
      if (eoc != 3'h0 && effective_config[`ADCMP_BIT_AUTO_DOZE]) begin
        dozing <= 1'b1;
      end else if (trig_rise != 3'h0) begin
        dozing <= 1'b0;
      end
    end
  end
  wire busy_raw = seq_mode ? ((converting != 3'h0) && !seq_pulse) : (converting != 3'h0);
  always_ff @(posedge mclk) begin
    if (master_reset) begin
      busy <= 1'b0;
    end else begin
      busy <= busy_raw ^ busy_pol;
    end
  end
  assign power.partial_down = partial;
  assign power.dozing = dozing;
endmodule
`default_nettype wire

// ---- tb/adcmp_host.sv ----
`timescale 1ns/1ps
`default_nettype none
// ****************
// host model
// ****************
module adcmp_host (
  input wire logic mclk,
  input wire logic [2:0] serial_result_out,
  output logic chip_select_n,
  output logic write_strobe_n,
  output logic [15:0] parallel_data_bus,
  output logic frame_sync_n,
  output logic sclk,
  output logic serial_in,
  output logic [2:0] chain_in
);
  // idle levels; sclk parks high between frames
  initial begin
    chip_select_n = 1'b1;
    write_strobe_n = 1'b1;
    parallel_data_bus = 16'h0000;
    frame_sync_n = 1'b1;
    sclk = 1'b1;
    serial_in = 1'b0;
    chain_in = 3'h5;
  end
  // captured lanes; extra clocks read the chained data behind the own word
  int extra = 0;
  logic [63:0] got_a, got_b, got_c;
  task automatic step(input int n);
    repeat (n) @(negedge mclk);
  endtask
  // all writes of one update under one chip select, done before any trigger
  task automatic par_seq(input int n, input logic [63:0] d);
    int i;
    chip_select_n = 1'b0;
    for (i = 0; i < n; i++) begin
      parallel_data_bus = d[63-16*i -: 16];
      write_strobe_n = 1'b0;
      step(4);
      write_strobe_n = 1'b1;
      step(6);
    end
    chip_select_n = 1'b1;
    // released bus shows the inverse so stale data cannot look valid
    parallel_data_bus = ~parallel_data_bus;
  endtask
  // combined read and write, msb first; 200 ns sclk is far below the chain limit
  task automatic ser_frame(input logic [31:0] w, output logic [31:0] r);
    int i;
    frame_sync_n = 1'b0;
    for (i = 31 + extra; i >= 0; i--) begin
      serial_in = (i >= extra) ? w[i - extra] : 1'b0;
      chain_in = ~chain_in;
      step(4);
      sclk = 1'b0;
      got_a[i] = serial_result_out[0];
      got_b[i] = serial_result_out[1];
      got_c[i] = serial_result_out[2];
      step(4);
      sclk = 1'b1;
    end
    r = got_a[31 + extra -: 32];
    step(4);
    frame_sync_n = 1'b1;
    serial_in = ~serial_in;
  endtask
endmodule
`default_nettype wire

// ---- tb/adcmp_ctrl_props.sv ----
`timescale 1ns/1ps
`default_nettype none
// ****************
// port checks
// ****************
module adcmp_ctrl_props
  import adcmp_pkg::*;
(
  input wire logic mclk,
  input wire logic srst,
  input wire logic reset_pin,
  input wire adcmp_pins_t pins,
  input wire logic write_strobe_n,
  input wire logic [31:0] configuration_word,
  input wire logic [31:0] effective_config,
  input wire adcmp_power_t power,
  input wire logic [2:0] pair_sampling,
  input wire logic busy
);
  // pins pass a two-flop sync, so levels must hold a few cycles first
  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);
  sequence sw_held;
    pins.control_source_select[*4];
  endsequence
  sequence hw_held;
    (!pins.control_source_select && !reset_pin)[*5];
  endsequence
  reset_value_a: assert property ($fell(srst) |->
    configuration_word == 32'h000003FF && !busy && pair_sampling == 3'h7)
    else $error("bad state after reset");
  pin_reset_a: assert property (reset_pin[*5] |->
    configuration_word == 32'h000003FF && pair_sampling == 3'h7)
    else $error("reset pin ignored");
  hw_view_a: assert property (hw_held |->
    effective_config == (configuration_word & 32'h007CE3FF))
    else $error("hardware view wrong");
  sw_view_a: assert property (sw_held |-> effective_config == configuration_word)
    else $error("software view wrong");
  hw_frozen_a: assert property (hw_held |=> $stable(configuration_word))
    else $error("word changed in hardware mode");
  strobe_idle_a: assert property (
    (write_strobe_n && !pins.serial_mode && !reset_pin)[*8] |=> $stable(configuration_word))
    else $error("word changed without strobe");
  standby_on_a: assert property ((!pins.sleep_request_n)[*4] |-> power.standby)
    else $error("standby missing");
  pd_map_a: assert property (sw_held |-> power.powerdown == configuration_word[15:13])
    else $error("pair power-down wrong");
endmodule
bind adcmp_ctrl adcmp_ctrl_props u_props (
  .mclk(mclk), .srst(srst), .reset_pin(reset_pin), .pins(pins),
  .write_strobe_n(write_strobe_n), .configuration_word(configuration_word),
  .effective_config(effective_config), .power(power),
  .pair_sampling(pair_sampling), .busy(busy)
);
`default_nettype wire

// ---- tb/testbench.sv ----
`timescale 1ns/1ps
`default_nettype none
// ****************
// bench
// ****************
module testbench
  import adcmp_pkg::*;
;
  typedef struct packed {
    logic byte_mode;
    logic [2:0] count;
    logic [63:0] data;
    logic [31:0] exp_word;
  } adcmp_row_t;
  logic mclk, srst, reset_pin, conv_clock, busy;
  adcmp_pins_t pins;
  adcmp_power_t power;
  logic [2:0] pair_convert_trigger, hw_pin_pd, pair_sampling, serial_result_out, chain_in;
  logic [95:0] result_data;
  logic chip_select_n, write_strobe_n, frame_sync_n, sclk, serial_in;
  logic [15:0] parallel_data_bus;
  logic [31:0] configuration_word, effective_config, rx;
  int errors, comparisons;
  adcmp_row_t rows [4] = '{
    '{1'b0, 3'h2, 64'hA5C3_0234_0000_0000, 32'hA5C30234},
    '{1'b0, 3'h1, 64'h5AFF_0000_0000_0000, 32'h5AC30234},
    '{1'b1, 3'h4, 64'h3C00_4700_A900_6600, 32'h3C47A966},
    '{1'b1, 3'h1, 64'h8100_0000_0000_0000, 32'h8147A966}};
  // short settle count keeps the run brief
  adcmp_ctrl #(.SETTLE_CYCLES(20)) uut (.mclk(mclk), .srst(srst), .reset_pin(reset_pin),
    .pins(pins), .chip_select_n(chip_select_n), .write_strobe_n(write_strobe_n),
    .parallel_data_bus(parallel_data_bus), .frame_sync_n(frame_sync_n), .sclk(sclk),
    .serial_in(serial_in), .chain_in(chain_in), .conv_clock(conv_clock),
    .pair_convert_trigger(pair_convert_trigger), .result_data(result_data),
    .hw_pin_pd(hw_pin_pd), .configuration_word(configuration_word),
    .effective_config(effective_config), .power(power), .pair_sampling(pair_sampling),
    .busy(busy), .serial_result_out(serial_result_out));
  adcmp_host host (.mclk(mclk), .serial_result_out(serial_result_out),
    .chip_select_n(chip_select_n), .write_strobe_n(write_strobe_n),
    .parallel_data_bus(parallel_data_bus), .frame_sync_n(frame_sync_n), .sclk(sclk),
    .serial_in(serial_in), .chain_in(chain_in));
  // clocks: 25 ns main, 100 ns conversion
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  initial begin
    conv_clock = 1'b0;
    forever begin
      repeat (2) @(negedge mclk);
      conv_clock = ~conv_clock;
    end
  end
  task automatic step(input int n);
    repeat (n) @(negedge mclk);
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("FAIL %0t %s", $time, what);
    end
  endtask
  // bounded wait, the check after it catches a miss
  task automatic wait_busy(input logic level, input int lim);
    int n;
    n = 0;
    while (busy !== level && n < lim) begin
      step(1);
      n++;
    end
  endtask
  task automatic close_out;
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // run needs about 45 us; a hang is cut off well after that
  initial begin
    #1000000;
    errors++;
    close_out();
  end
  // main sequence
  initial begin
    errors = 0;
    comparisons = 0;
    srst = 1'b1;
    reset_pin = 1'b0;
    pins = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b0};
    pair_convert_trigger = 3'h0;
    result_data = {32'h1E2D3C4B, 32'h5A697887, 32'hC35A0F96};
    hw_pin_pd = 3'h0;
    step(2);
    srst = 1'b0;
    step(4);
    check(configuration_word, 32'h000003FF, "reset word");
    check(pair_sampling, 32'h7, "sampling");
    $display("reset done");
    for (int i = 0; i < 4; i++) begin
      pins.byte_mode = rows[i].byte_mode;
      step(4);
      host.par_seq(rows[i].count, rows[i].data);
      step(6);
      check(configuration_word, rows[i].exp_word, "parallel update");
    end
    $display("parallel done");
    pins.control_source_select = 1'b0;
    pins.byte_mode = 1'b0;
    step(4);
    host.par_seq(2, 64'h1111_2222_0000_0000);
    step(6);
    check(configuration_word, 32'h8147A966, "hw write");
    check(effective_config, 32'h0044A166, "hw view");
    hw_pin_pd = 3'h4;
    step(4);
    check(power.powerdown, 32'h4, "pin power-down");
    pair_convert_trigger = 3'h1;
    wait_busy(1'b1, 40);
    check(busy, 32'h1, "busy rise");
    pair_convert_trigger = 3'h0;
    wait_busy(1'b0, 100);
    check(power.partial_down, 32'h1, "partial down");
    reset_pin = 1'b1;
    step(5);
    reset_pin = 1'b0;
    step(5);
    check(power.partial_down, 32'h0, "woken");
    check(configuration_word, 32'h000003FF, "pin reset");
    $display("hardware done");
    pins.control_source_select = 1'b1;
    pins.serial_mode = 1'b1;
    step(4);
    check(effective_config, 32'h000003FF, "sw view");
    host.ser_frame(32'h8E034020, rx);
    step(4);
    check(configuration_word, 32'h8E034020, "full frame");
    check(rx, 32'hC35A0F96, "result out");
    check(host.got_b[31:0], 32'h5A697887, "lane b");
    check(host.got_c[31:0], 32'h1E2D3C4B, "lane c");
    host.ser_frame(32'h77000000, rx);
    step(4);
    check(configuration_word, 32'h77034020, "top byte");
    check(rx, 32'h8E034020, "word readback");
    check(power.powerdown, 32'h2, "pair off");
    // chain: 32 extra clocks bring the toggling chain inputs out behind the word
    pins.chain_enable = 1'b1;
    host.extra = 32;
    step(4);
    host.ser_frame(32'h00000000, rx);
    step(4);
    check(configuration_word, 32'h00034020, "chain word");
    check(rx, 32'h77034020, "chain head");
    check(host.got_a[31:0], 32'hAAAAAAAA, "chain a");
    check(host.got_b[31:0], 32'h55555555, "chain b");
    check(host.got_c[31:0], 32'hAAAAAAAA, "chain c");
    host.extra = 0;
    pins.chain_enable = 1'b0;
    $display("serial done");
    // sequential mode with auto-doze; triggers sit in the high phase of conv_clock
    host.ser_frame(32'h00C10800, rx);
    step(4);
    check(configuration_word, 32'h00C10800, "seq word");
    @(posedge conv_clock);
    step(1);
    pair_convert_trigger = 3'h1;
    step(20);
    pair_convert_trigger = 3'h3;
    wait_busy(1'b1, 40);
    wait_busy(1'b0, 120);
    check(busy, 32'h0, "eoc pulse");
    wait_busy(1'b1, 8);
    check(busy, 32'h1, "others busy");
    wait_busy(1'b0, 60);
    check(busy, 32'h0, "all done");
    check(power.dozing, 32'h1, "dozing");
    pair_convert_trigger = 3'h0;
    $display("sequential done");
    pins.sleep_request_n = 1'b0;
    step(4);
    check(power.standby, 32'h1, "standby");
    check(configuration_word, 32'h00C10800, "kept");
    pins.sleep_request_n = 1'b1;
    step(4);
    check(power.ready, 32'h0, "settling");
    step(30);
    check(power.ready, 32'h1, "ready");
    $display("standby done");
    close_out();
  end
endmodule
`default_nettype wire
